// *** core/nvs_cycle.sv ***
// Single parallel bus cycle engine driving the memory pins
`timescale 1ns/1ps
`default_nettype none
module nvs_cycle (
  input  wire logic              aclk,        // System clock
  input  wire logic              aresetn,     // Sync reset, active low
  input  wire logic              req_valid,   // Cycle request
  output logic                   req_ready,   // Engine idle
  input  wire nvs_pkg::nvs_req_t req,         // Cycle descriptor
  output logic                   done,        // Cycle finished pulse
  output logic [7:0]             rdata,       // Captured read data
  input  wire logic [7:0]        dq_i,        // Data pins in
  output nvs_pkg::nvs_pins_t     pins         // Pin outputs
);
  typedef enum logic [1:0] {
    CY_IDLE  = 2'b00,
    CY_SETUP = 2'b01,
    CY_STRB  = 2'b10
  } nvs_cy_t;
  nvs_cy_t            st_reg, st_next;        // Engine state
  logic [7:0]         cnt_reg, cnt_next;      // Phase counter
  nvs_pkg::nvs_req_t  cur_reg, cur_next;      // Latched request
  logic [7:0]         rd_reg, rd_next;        // Read data
  logic               done_reg, done_next;    // Done pulse
  nvs_pkg::nvs_pins_t pin_reg, pin_next;      // Pin flops

  assign req_ready = (st_reg == CY_IDLE);
  assign done      = done_reg;
  assign rdata     = rd_reg;
  assign pins      = pin_reg;

  // Next state of the cycle engine
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    cur_next  = cur_reg;
    rd_next   = rd_reg;
    done_next = 1'b0;
    pin_next  = pin_reg;
    unique case (st_reg)
      CY_IDLE: begin
        if (req_valid) begin
          cur_next      = req;
          pin_next.addr = req.addr;
          pin_next.dq_o = req.wdata;
          cnt_next      = 8'(nvs_pkg::CYC_SETUP);
          st_next       = CY_SETUP;
        end
      end
      CY_SETUP: begin
        // Address settles before any strobe
        if (cnt_reg <= 8'h01) begin
          pin_next.ce_n  = 1'b0;
          pin_next.oe_n  = cur_reg.write;
          // Write strobe only for writes, high through reads
          pin_next.we_n  = ~cur_reg.write;
          pin_next.dq_oe = cur_reg.write;
          cnt_next       = 8'(nvs_pkg::CYC_ACCESS);
          st_next        = CY_STRB;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      CY_STRB: begin
        if (cnt_reg <= 8'h01) begin
          rd_next   = cur_reg.write ? rd_reg : dq_i;
          pin_next.ce_n  = 1'b1;
          pin_next.oe_n  = 1'b1;
          pin_next.we_n  = 1'b1;
          pin_next.dq_oe = 1'b0;
          done_next = 1'b1;
          st_next   = CY_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: st_next = CY_IDLE;
    endcase
  end

  // Register update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg   <= CY_IDLE;
      cnt_reg  <= 8'h00;
      cur_reg  <= '0;
      rd_reg   <= 8'h00;
      done_reg <= 1'b0;
      pin_reg  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                    addr: 15'h0000, dq_o: 8'h00, dq_oe: 1'b0};
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      cur_reg  <= cur_next;
      rd_reg   <= rd_next;
      done_reg <= done_next;
      pin_reg  <= pin_next;
    end
  end
endmodule : nvs_cycle
`default_nettype wire

// *** core/nvs_host.sv ***
// Host controller issuing nvSRAM command sequences over AXI4-Lite orders
`timescale 1ns/1ps
`default_nettype none
module nvs_host (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Sync reset, active low
  input  wire logic [3:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write strobes
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [3:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  output logic             mem_ce_n,      // Chip select, active low
  output logic             mem_oe_n,      // Output enable, active low
  output logic             mem_we_n,      // Write strobe, active low
  output logic [14:0]      mem_addr,      // Address lines
  input  wire logic [7:0]  mem_dq_i,      // Data lines in
  output logic [7:0]       mem_dq_o,      // Data lines out
  output logic             mem_dq_oe,     // Data lines drive enable
  input  wire logic        store_busy_n_i // Busy pin from device
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_ISSUE = 3'b001,
    HS_WAIT = 3'b010,
    HS_BUSY = 3'b011
  } nvs_hs_t;

  // Final address of each command sequence
  function automatic logic [14:0] final_addr(input nvs_pkg::nvs_cmd_t c);
    unique case (c)
      nvs_pkg::NVS_CMD_STORE:  final_addr = nvs_pkg::SEQ_STORE;
      nvs_pkg::NVS_CMD_RECALL: final_addr = nvs_pkg::SEQ_RECALL;
      nvs_pkg::NVS_CMD_PLSOFF: final_addr = nvs_pkg::SEQ_PLS_OFF;
      nvs_pkg::NVS_CMD_PLSON:  final_addr = nvs_pkg::SEQ_PLS_ON;
      default:                 final_addr = nvs_pkg::SEQ_A1;
    endcase
  endfunction : final_addr

  // Address of a given step of a sequence
  function automatic logic [14:0] step_addr(input logic [2:0] s,
                                            input nvs_pkg::nvs_cmd_t c);
    unique case (s)
      3'h0:    step_addr = nvs_pkg::SEQ_A1;
      3'h1:    step_addr = nvs_pkg::SEQ_A2;
      3'h2:    step_addr = nvs_pkg::SEQ_A3;
      3'h3:    step_addr = nvs_pkg::SEQ_A4;
      3'h4:    step_addr = nvs_pkg::SEQ_A5;
      default: step_addr = final_addr(c);
    endcase
  endfunction : step_addr

  nvs_hs_t           st_reg, st_next;       // Sequencer state
  nvs_pkg::nvs_cmd_t cmd_reg, cmd_next;     // Active command
  logic [2:0]        step_reg, step_next;   // Sequence step
  logic [14:0]       addr_reg, addr_next;   // Single op address
  logic [7:0]        data_reg, data_next;   // Single op data
  logic              pls_reg, pls_next;     // Power-loss store shadow
  logic              abt_reg, abt_next;     // Abort flag, cleared at start and never set
  logic              aw_reg, aw_next;       // Address taken
  logic              w_reg, w_next;         // Data taken
  logic [3:0]        awa_reg, awa_next;     // Held write address
  logic [31:0]       wd_reg, wd_next;       // Held write data
  logic [3:0]        ws_reg, ws_next;       // Held write strobes
  logic              bv_reg, bv_next;       // Response pending
  logic [1:0]        br_reg, br_next;       // Response code
  logic              rv_reg, rv_next;       // Read pending
  logic [31:0]       rd_reg, rd_next;       // Read data
  logic [1:0]        rr_reg, rr_next;       // Read code
  logic              cy_valid;              // Cycle request
  logic              cy_ready;              // Engine idle
  logic              cy_done;               // Cycle done
  logic [7:0]        cy_rdata;              // Cycle read data
  nvs_pkg::nvs_req_t cy_req;                // Cycle descriptor
  nvs_pkg::nvs_pins_t pins;                 // Pin group
  logic              busy;                  // Sequencer busy
  logic              wr_go;                 // Write commit

  // One bus cycle at a time on the memory pins
  nvs_cycle u_cycle (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .req_valid (cy_valid),
    .req_ready (cy_ready),
    .req       (cy_req),
    .done      (cy_done),
    .rdata     (cy_rdata),
    .dq_i      (mem_dq_i),
    .pins      (pins)
  );

  assign mem_ce_n  = pins.ce_n;
  assign mem_oe_n  = pins.oe_n;
  assign mem_we_n  = pins.we_n;
  assign mem_addr  = pins.addr;
  assign mem_dq_o  = pins.dq_o;
  assign mem_dq_oe = pins.dq_oe;
  assign busy      = (st_reg != HS_IDLE);

  // Sequence steps issue reads, single writes only for the write order
  assign cy_valid      = (st_reg == HS_ISSUE) && cy_ready;
  assign cy_req.write  = (cmd_reg == nvs_pkg::NVS_CMD_WRITE);
  assign cy_req.addr   = (cmd_reg == nvs_pkg::NVS_CMD_READ ||
                          cmd_reg == nvs_pkg::NVS_CMD_WRITE) ? addr_reg :
                         step_addr(step_reg, cmd_reg);
  assign cy_req.wdata  = data_reg;

  // AXI ready and response outputs
  assign s_awready = !aw_reg && !bv_reg;
  assign s_wready  = !w_reg && !bv_reg;
  assign s_bvalid  = bv_reg;
  assign s_bresp   = br_reg;
  assign s_arready = !rv_reg;
  assign s_rvalid  = rv_reg;
  assign s_rdata   = rd_reg;
  assign s_rresp   = rr_reg;
  assign wr_go     = aw_reg && w_reg && !bv_reg;

  // Sequencer and register file next values
  always_comb begin
    st_next   = st_reg;
    cmd_next  = cmd_reg;
    step_next = step_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    pls_next  = pls_reg;
    abt_next  = abt_reg;
    aw_next   = aw_reg;
    w_next    = w_reg;
    awa_next  = awa_reg;
    wd_next   = wd_reg;
    ws_next   = ws_reg;
    bv_next   = bv_reg;
    br_next   = br_reg;
    rv_next   = rv_reg;
    rd_next   = rd_reg;
    rr_next   = rr_reg;
    // Capture address and data in either order
    if (s_awvalid && s_awready) begin
      aw_next  = 1'b1;
      awa_next = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_next  = 1'b1;
      wd_next = s_wdata;
      ws_next = s_wstrb;
    end
    if (wr_go) begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = nvs_pkg::RESP_OKAY;
      unique case (awa_reg)
        nvs_pkg::OFF_ADDR: if (ws_reg[1:0] == 2'b11)
          addr_next = wd_reg[14:0];
        nvs_pkg::OFF_DATA: if (ws_reg[0]) data_next = wd_reg[7:0];
        nvs_pkg::OFF_CTRL: begin
          // Start only when the sequencer is idle and the command code is at most 5
          if (wd_reg[nvs_pkg::CTRL_GO_BIT] && !busy && wd_reg[2:0] <= 3'h5)
          begin
            cmd_next  = nvs_pkg::nvs_cmd_t'(wd_reg[2:0]);
            step_next = 3'h0;
            abt_next  = 1'b0;
            st_next   = HS_ISSUE;
          end else if (wd_reg[nvs_pkg::CTRL_GO_BIT]) begin
            br_next = nvs_pkg::RESP_SLVERR;
          end
        end
        nvs_pkg::OFF_STAT: br_next = nvs_pkg::RESP_SLVERR;
        default:           br_next = nvs_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_reg && s_bready) bv_next = 1'b0;
    // Register reads
    if (s_arvalid && s_arready) begin
      rv_next = 1'b1;
      rr_next = nvs_pkg::RESP_OKAY;
      unique case (s_araddr)
        nvs_pkg::OFF_CTRL: rd_next = {29'h0, cmd_reg};
        nvs_pkg::OFF_STAT: rd_next = {28'h0, abt_reg, ~store_busy_n_i,
                                      pls_reg, busy};
        nvs_pkg::OFF_ADDR: rd_next = {17'h0, addr_reg};
        nvs_pkg::OFF_DATA: rd_next = {24'h0, data_reg};
        default: begin
          rd_next = 32'h0000_0000;
          rr_next = nvs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_reg && s_rready) begin
      rv_next = 1'b0;
    end
    // Command sequencer
    unique case (st_reg)
      HS_IDLE: ;
      HS_ISSUE: begin
        // Device refuses access while its busy pin is low
        if (!store_busy_n_i) st_next = HS_BUSY;
        else if (cy_ready) st_next = HS_WAIT;
      end
      HS_WAIT: begin
        if (cy_done) begin
          if (cmd_reg == nvs_pkg::NVS_CMD_READ ||
              cmd_reg == nvs_pkg::NVS_CMD_WRITE) begin
            if (cmd_reg == nvs_pkg::NVS_CMD_READ) data_next = cy_rdata;
            st_next = HS_BUSY;
          end else if (step_reg == 3'h5) begin
            // Shadow of the device power-loss store flag
            if (cmd_reg == nvs_pkg::NVS_CMD_PLSOFF) pls_next = 1'b0;
            if (cmd_reg == nvs_pkg::NVS_CMD_PLSON)  pls_next = 1'b1;
            st_next = HS_BUSY;
          end else begin
            // Back to back reads, no other access between
            step_next = step_reg + 3'h1;
            st_next   = HS_ISSUE;
          end
        end
      end
      HS_BUSY: begin
        // Hold off next order until busy pin is high again
        if (store_busy_n_i) st_next = HS_IDLE;
      end
      default: st_next = HS_IDLE;
    endcase
  end

  // Register update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg   <= HS_IDLE;
      cmd_reg  <= nvs_pkg::NVS_CMD_READ;
      step_reg <= 3'h0;
      addr_reg <= 15'h0000;
      data_reg <= 8'h00;
      pls_reg  <= 1'b1;
      abt_reg  <= 1'b0;
      aw_reg   <= 1'b0;
      w_reg    <= 1'b0;
      awa_reg  <= 4'h0;
      wd_reg   <= 32'h0000_0000;
      ws_reg   <= 4'h0;
      bv_reg   <= 1'b0;
      br_reg   <= 2'h0;
      rv_reg   <= 1'b0;
      rd_reg   <= 32'h0000_0000;
      rr_reg   <= 2'h0;
    end else begin
      st_reg   <= st_next;
      cmd_reg  <= cmd_next;
      step_reg <= step_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      pls_reg  <= pls_next;
      abt_reg  <= abt_next;
      aw_reg   <= aw_next;
      w_reg    <= w_next;
      awa_reg  <= awa_next;
      wd_reg   <= wd_next;
      ws_reg   <= ws_next;
      bv_reg   <= bv_next;
      br_reg   <= br_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
      rr_reg   <= rr_next;
    end
  end

  // Checks on the pin sequence
  property p_we_high_seq;
    @(posedge aclk) disable iff (!aresetn)
      (!mem_ce_n && cmd_reg != nvs_pkg::NVS_CMD_WRITE) |-> mem_we_n;
  endproperty
  a_we_high_seq: assert property (p_we_high_seq)
    else $error("write strobe low during sequence");
  property p_no_drive_read;
    @(posedge aclk) disable iff (!aresetn)
      (!mem_oe_n) |-> !mem_dq_oe;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read)
    else $error("data driven during read");
  property p_step_addr;
    @(posedge aclk) disable iff (!aresetn)
      ($fell(mem_ce_n) && step_reg == 3'h0 && st_reg == HS_WAIT &&
       cmd_reg >= nvs_pkg::NVS_CMD_STORE) |-> mem_addr == nvs_pkg::SEQ_A1;
  endproperty
  a_step_addr: assert property (p_step_addr)
    else $error("sequence does not start at first address");
  property p_final_recall;
    @(posedge aclk) disable iff (!aresetn)
      ($fell(mem_ce_n) && step_reg == 3'h5 &&
       cmd_reg == nvs_pkg::NVS_CMD_RECALL) |->
        mem_addr == nvs_pkg::SEQ_RECALL;
  endproperty
  a_final_recall: assert property (p_final_recall)
    else $error("recall final address wrong");
  property p_pls_off;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == HS_WAIT && cy_done && step_reg == 3'h5 &&
       cmd_reg == nvs_pkg::NVS_CMD_PLSOFF) |=> !pls_reg;
  endproperty
  a_pls_off: assert property (p_pls_off)
    else $error("power-loss flag not cleared");
  property p_pls_on;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == HS_WAIT && cy_done && step_reg == 3'h5 &&
       cmd_reg == nvs_pkg::NVS_CMD_PLSON) |=> pls_reg;
  endproperty
  a_pls_on: assert property (p_pls_on)
    else $error("power-loss flag not set");
  property p_busy_hold;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == HS_BUSY && !store_busy_n_i) |=> st_reg == HS_BUSY;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("left busy wait while pin low");
  property p_step_adv;
    @(posedge aclk) disable iff (!aresetn)
      (st_reg == HS_WAIT && cy_done && step_reg < 3'h5 &&
       cmd_reg >= nvs_pkg::NVS_CMD_STORE) |=>
        step_reg == $past(step_reg) + 3'h1;
  endproperty
  a_step_adv: assert property (p_step_adv)
    else $error("sequence step did not advance");
  c_store: cover property (@(posedge aclk) cy_done && step_reg == 3'h5 &&
    cmd_reg == nvs_pkg::NVS_CMD_STORE);
  c_recall: cover property (@(posedge aclk) cy_done && step_reg == 3'h5 &&
    cmd_reg == nvs_pkg::NVS_CMD_RECALL);
  c_plsoff: cover property (@(posedge aclk) cy_done && step_reg == 3'h5 &&
    cmd_reg == nvs_pkg::NVS_CMD_PLSOFF);
endmodule : nvs_host
`default_nettype wire

// *** core/nvs_pkg.sv ***
// Package with command addresses, timing counts and carrier types
`default_nettype none
package nvs_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000; // System clock rate
  localparam int unsigned ADDR_W        = 15;         // Address lines width
  localparam int unsigned DATA_W        = 8;          // Data lines width
  // Command sequence addresses (lower 14 bits used by the device)
  localparam logic [14:0] SEQ_A1        = 15'h0E38;   // First step
  localparam logic [14:0] SEQ_A2        = 15'h31C7;   // Second step
  localparam logic [14:0] SEQ_A3        = 15'h03E0;   // Third step
  localparam logic [14:0] SEQ_A4        = 15'h3C1F;   // Fourth step
  localparam logic [14:0] SEQ_A5        = 15'h303F;   // Fifth step
  localparam logic [14:0] SEQ_STORE     = 15'h0FC0;   // Final: store
  localparam logic [14:0] SEQ_RECALL    = 15'h0C63;   // Final: recall
  localparam logic [14:0] SEQ_PLS_OFF   = 15'h0B45;   // Final: disable
  localparam logic [14:0] SEQ_PLS_ON    = 15'h0B46;   // Final: enable
  // Bus cycle timing in ns and derived cycle counts (least, round up)
  localparam int unsigned T_CYCLE_NS    = 50;         // Read cycle length
  localparam int unsigned T_SETUP_NS    = 25;         // Address setup
  localparam int unsigned CYC_ACCESS    =
    (T_CYCLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // Strobe cycles
  localparam int unsigned CYC_SETUP     =
    (T_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // Setup cycles
  // Register offsets of the AXI4-Lite control block
  localparam logic [3:0]  OFF_CTRL      = 4'h0;       // Command register
  localparam logic [3:0]  OFF_STAT      = 4'h4;       // Status register
  localparam logic [3:0]  OFF_ADDR      = 4'h8;       // Single op address
  localparam logic [3:0]  OFF_DATA      = 4'hC;       // Single op data
  localparam int unsigned CTRL_GO_BIT   = 31;         // Start bit position
  localparam int unsigned STAT_BUSY_BIT = 0;          // Busy bit position
  localparam int unsigned STAT_PLS_BIT  = 1;          // Power-loss-store flag
  localparam int unsigned STAT_NVB_BIT  = 2;          // Device busy pin low
  localparam int unsigned STAT_ABT_BIT  = 3;          // Sequence aborted flag, never set, reads 0
  localparam logic [1:0]  RESP_OKAY     = 2'h0;       // AXI okay
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;       // AXI slave error
  // Host commands
  typedef enum logic [2:0] {
    NVS_CMD_READ   = 3'b000,
    NVS_CMD_WRITE  = 3'b001,
    NVS_CMD_STORE  = 3'b010,
    NVS_CMD_RECALL = 3'b011,
    NVS_CMD_PLSOFF = 3'b100,
    NVS_CMD_PLSON  = 3'b101
  } nvs_cmd_t;
  // One bus cycle request towards the pin engine
  typedef struct packed {
    logic              write;
    logic [14:0]       addr;
    logic [7:0]        wdata;
  } nvs_req_t;
  // Device pin outputs
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [14:0]       addr;
    logic [7:0]        dq_o;
    logic              dq_oe;
  } nvs_pins_t;
endpackage : nvs_pkg
`default_nettype wire

// *** verification/nvs_dev_model.sv ***
// Behavioural memory device with command sequence decoder
`timescale 1ns/1ps
`default_nettype none
module nvs_dev_model #(
  parameter int BUSY_CYC = 40  // Busy span of a store or recall
) (
  input  wire logic        aclk,   // Model clock
  input  wire logic        ce_n,   // Chip select
  input  wire logic        oe_n,   // Output enable
  input  wire logic        we_n,   // Write strobe
  input  wire logic [14:0] addr,   // Address lines
  input  wire logic [7:0]  din,    // Resolved data lines
  output logic      [7:0]  dq,     // Driven read data
  output logic             busy_n, // Busy pin
  output logic             pls     // Power-loss store flag
);
  localparam logic [14:0] SEQ [5] = '{nvs_pkg::SEQ_A1, nvs_pkg::SEQ_A2,
    nvs_pkg::SEQ_A3, nvs_pkg::SEQ_A4, nvs_pkg::SEQ_A5};
  logic [7:0]  mem [32768];     // Volatile cells
  logic [7:0]  nv  [32768];     // Nonvolatile cells
  logic [2:0]  st  = 3'h0;      // Sequence step
  logic        c_q = 1'b1;      // Chip select last edge
  logic        w_q = 1'b1;      // Write strobe last edge
  logic [14:0] a_q;             // Address last edge
  logic [7:0]  d_q;             // Data last edge
  logic [7:0]  junk = 8'h5A;    // Changing pattern when not driven
  int          bc  = 0;         // Busy cycles left
  initial begin
    pls = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (nv[i]) nv[i] = 8'h00;
  end
  // Decode at cycle start, write at cycle end, busy countdown
  always @(posedge aclk) begin
    c_q  <= ce_n;
    junk <= junk + 8'h3B;
    if (bc > 0) bc <= bc - 1;
    if (!ce_n) begin
      a_q <= addr;
      w_q <= we_n;
      d_q <= din;
    end
    if (!ce_n && c_q && bc == 0) begin
      if (!we_n) st <= 3'h0;
      else if (st < 3'h5) st <= (addr[13:0] == SEQ[st][13:0]) ? st + 3'h1 :
        3'(addr[13:0] == nvs_pkg::SEQ_A1[13:0]);
      else begin
        st <= 3'h0;
        case (addr[13:0])
          nvs_pkg::SEQ_STORE[13:0]: begin
            nv <= mem;
            bc <= BUSY_CYC;
          end
          nvs_pkg::SEQ_RECALL[13:0]: begin
            mem <= nv;
            bc  <= BUSY_CYC;
          end
          nvs_pkg::SEQ_PLS_OFF[13:0]: pls <= 1'b0;
          nvs_pkg::SEQ_PLS_ON[13:0]:  pls <= 1'b1;
          default: ;
        endcase
      end
    end
    if (ce_n && !c_q && !w_q && bc == 0) mem[a_q] <= d_q;
  end
  assign busy_n = (bc == 0);
  // Drive only on a plain read while idle, store or recall final step floats
  assign dq = (!ce_n && !oe_n && we_n && bc == 0) ? mem[addr] :
              junk;
endmodule : nvs_dev_model
`default_nettype wire

// *** verification/nvs_host_tb.sv ***
// Self-checking bench of the host controller with device model
`timescale 1ns/1ps
`default_nettype none
module nvs_host_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rv;
  logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n;
  logic dq_oe, busy_n, pls;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [14:0] maddr, a0;
  logic [7:0] dq_o, dq_m, dq_w, v0, v1;
  logic [65:0] q [$];            // Expected read notes
  int n_checks = 0, miscompares = 0;
  always #12.5 aclk = ~aclk;
  assign dq_w = dq_oe ? dq_o : dq_m;
  nvs_host u_nvs_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .mem_ce_n(ce_n),
    .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_addr(maddr), .mem_dq_i(dq_w),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .store_busy_n_i(busy_n));
  nvs_dev_model u_nvs_dev_model (.aclk(aclk), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(maddr), .din(dq_w), .dq(dq_m), .busy_n(busy_n),
    .pls(pls));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(r));
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] m,
    input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    q.push_back({r, m, e});
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rready <= 1'b0;
  endtask : rd
  // Issue one command and poll busy until clear
  task automatic op(input nvs_pkg::nvs_cmd_t c, input logic [14:0] a,
    input logic [7:0] d);
    wr(nvs_pkg::OFF_ADDR, 32'(a), nvs_pkg::RESP_OKAY);
    wr(nvs_pkg::OFF_DATA, 32'(d), nvs_pkg::RESP_OKAY);
    wr(nvs_pkg::OFF_CTRL, 32'h8000_0000 | 32'(c), nvs_pkg::RESP_OKAY);
    do rd(nvs_pkg::OFF_STAT, 32'h0, 32'h0, nvs_pkg::RESP_OKAY);
    while (rv[0] !== 1'b0);
  endtask : op
  // Oldest note against each read answer
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready && q.size() > 0) begin
      chk(rdata & q[0][63:32], q[0][31:0]);
      chk(32'(rresp), 32'(q[0][65:64]));
      void'(q.pop_front());
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #(25 * 80000);
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(80));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(nvs_pkg::OFF_STAT, 32'hF, 32'h2, nvs_pkg::RESP_OKAY);
    rd(4'h2, 32'hFFFF_FFFF, 32'h0, nvs_pkg::RESP_SLVERR);
    wr(nvs_pkg::OFF_STAT, 32'h0, nvs_pkg::RESP_SLVERR);
    $display("test registers done");
    op(nvs_pkg::NVS_CMD_READ, 15'h7FFF, 8'h00);
    rd(nvs_pkg::OFF_DATA, 32'hFF, 32'h0, nvs_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      a0 = 15'($urandom);
      v0 = 8'($urandom);
      op(nvs_pkg::NVS_CMD_WRITE, a0, v0);
      op(nvs_pkg::NVS_CMD_READ, a0, 8'h00);
      rd(nvs_pkg::OFF_DATA, 32'hFF, 32'(v0), nvs_pkg::RESP_OKAY);
    end
    $display("test access done");
    op(nvs_pkg::NVS_CMD_STORE, 15'h0, 8'h0);
    chk(32'(u_nvs_dev_model.nv[a0]), 32'(v0));
    v1 = ~v0;
    op(nvs_pkg::NVS_CMD_WRITE, a0, v1);
    op(nvs_pkg::NVS_CMD_RECALL, 15'h0, 8'h0);
    op(nvs_pkg::NVS_CMD_READ, a0, 8'h00);
    rd(nvs_pkg::OFF_DATA, 32'hFF, 32'(v0), nvs_pkg::RESP_OKAY);
    chk(32'(u_nvs_dev_model.nv[a0]), 32'(v0));
    $display("test store recall done");
    wr(nvs_pkg::OFF_CTRL, 32'h8000_0007, nvs_pkg::RESP_SLVERR);
    wr(nvs_pkg::OFF_CTRL, 32'h8000_0000 | 32'(nvs_pkg::NVS_CMD_STORE),
      nvs_pkg::RESP_OKAY);
    wr(nvs_pkg::OFF_CTRL, 32'h8000_0000, nvs_pkg::RESP_SLVERR);
    rd(nvs_pkg::OFF_STAT, 32'h1, 32'h1, nvs_pkg::RESP_OKAY);
    do rd(nvs_pkg::OFF_STAT, 32'h0, 32'h0, nvs_pkg::RESP_OKAY);
    while (rv[0] !== 1'b0);
    op(nvs_pkg::NVS_CMD_PLSOFF, 15'h0, 8'h0);
    rd(nvs_pkg::OFF_STAT, 32'h2, 32'h0, nvs_pkg::RESP_OKAY);
    chk(32'(pls), 32'h0);
    op(nvs_pkg::NVS_CMD_STORE, 15'h0, 8'h0);
    op(nvs_pkg::NVS_CMD_PLSON, 15'h0, 8'h0);
    rd(nvs_pkg::OFF_STAT, 32'h2, 32'h2, nvs_pkg::RESP_OKAY);
    chk(32'(pls), 32'h1);
    op(nvs_pkg::NVS_CMD_STORE, 15'h0, 8'h0);
    $display("test power-loss store done");
    print_verdict();
  end
endmodule : nvs_host_tb
`default_nettype wire
